// [irda_defs.svh]
`ifndef IRDA_DEFS_SVH
`define IRDA_DEFS_SVH

// Counter width for bit period and pulse timing
`define IRDA_CNT_W 16
// Serial frame length in bit cells: start, 8 data, stop
`define IRDA_FRAME_BITS 10
// Smallest bit period the codec can serve, in clocks
`define IRDA_MIN_PERIOD 16
// System clock rate
`define IRDA_CLK_MHZ 125
// Link starts at this rate; software changes it later
`define IRDA_BOOT_BPS 9600
// Shortest legal transmit pulse, in ns
`define IRDA_MIN_PULSE_NS 1410
// Shortest pulse in clocks, rounded up
`define IRDA_MIN_PULSE_CYC ((`IRDA_MIN_PULSE_NS * `IRDA_CLK_MHZ + 999) / 1000)
// Fixed part of the upper pulse bound, in ns
`define IRDA_EXTRA_PULSE_NS 1080
// Fixed upper slack in clocks, rounded down
`define IRDA_EXTRA_PULSE_CYC ((`IRDA_EXTRA_PULSE_NS * `IRDA_CLK_MHZ) / 1000)
// Relative upper slack: one fortieth of a bit period
`define IRDA_SLACK_DIV 40
// Select code meaning three sixteenths of a bit period
`define IRDA_PWS_DEFAULT 3'h0
// Depth of the transmit bit buffer
`define IRDA_FIFO_DEPTH 32

`endif

// [irda_pkg.sv]
`default_nettype none
package irda_pkg;
  `include "irda_defs.svh"

  // Transmit sampler states
  typedef enum logic [0:0] {ENC_IDLE, ENC_RUN} enc_state_t;

  // Whole codec state
  typedef struct packed {
    enc_state_t enc;
    logic [`IRDA_CNT_W-1:0] cell_cnt;
    logic [3:0] frame_cnt;
    logic gen_busy;
    logic gen_bit;
    logic [`IRDA_CNT_W-1:0] gen_cnt;
    logic [2:0] rx_sync;
    logic rx_level;
    logic [`IRDA_CNT_W-1:0] rx_hold;
    logic ir_tx;
    logic ser_rx;
  } codec_state_t;
endpackage
`default_nettype wire

// [irda_bit_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module irda_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointers need a power of two to wrap cleanly; refused at elaboration
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("irda_bit_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
  end

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t s_r; // Registered pointers
  fifo_state_t s_nxt; // Next pointers
  logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = (s_r.count != DEPTH[AW:0]);
  assign out_valid = (s_r.count != '0);
  assign out_data = mem[s_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    // Simultaneous push and pop leaves count alone
    if (push && !pop) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_r.wr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [irda_pulse_codec.sv]
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - enable routes channel zero through codec
// - zero bit sends one high pulse
// - one bit sends no pulse
// - three-bit select sets pulse width
// - pulse capped at upper bound, then floored at minimum
// - select can reach the minimum width
// - received pulse gives zero, none gives one
// - short received pulses still count as zero
module irda_pulse_codec import irda_pkg::*; #(
  parameter int FRAME_BITS = `IRDA_FRAME_BITS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic infrared_enable,
  input wire logic [2:0] pulse_width_select,
  input wire logic [`IRDA_CNT_W-1:0] bit_period_cycles,
  input wire logic serial_tx_line_ch0,
  output logic serial_rx_line_ch0,
  input wire logic infrared_rx_pin,
  output logic infrared_tx_pin
);

  // Frame counter is four bits wide, so refuse longer frames at elaboration
  if (FRAME_BITS < 2 || FRAME_BITS > 15) begin : g_bad_frame
    $error("irda_pulse_codec: FRAME_BITS must lie in 2..15");
  end

  localparam logic [`IRDA_CNT_W-1:0] MIN_PERIOD = `IRDA_CNT_W'(`IRDA_MIN_PERIOD);
  localparam logic [`IRDA_CNT_W-1:0] MIN_PULSE = `IRDA_CNT_W'(`IRDA_MIN_PULSE_CYC);
  localparam logic [`IRDA_CNT_W-1:0] EXTRA_PULSE = `IRDA_CNT_W'(`IRDA_EXTRA_PULSE_CYC);
  localparam logic [3:0] LAST_CELL = 4'(FRAME_BITS - 1);

  codec_state_t s_r; // Registered state
  codec_state_t s_nxt; // Next state
  logic [`IRDA_CNT_W-1:0] period; // Bit period, floored to a safe size
  logic [`IRDA_CNT_W-1:0] width; // Transmit pulse width in clocks
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_bit;
  logic sample_now; // Mid-cell sample of the serial line
  logic gen_free; // Generator can take the next cell
  logic rx_rise; // Start of a received pulse

  ////////////////////////////////////////////////////////////////////
  // Pulse width from the select code
  ////////////////////////////////////////////////////////////////////

  // Three sixteenths of a period or a power-of-two count, then clamp into the legal window
  function automatic logic [`IRDA_CNT_W-1:0] pulse_width(
    input logic [2:0] sel,
    input logic [`IRDA_CNT_W-1:0] per
  );
    logic [`IRDA_CNT_W+1:0] three16;
    logic [`IRDA_CNT_W+1:0] slack;
    logic [`IRDA_CNT_W+1:0] upper;
    logic [`IRDA_CNT_W+1:0] w;
    // Product stays below 2^18 for any 16-bit period, so the cut loses nothing
    three16 = (`IRDA_CNT_W+2)'(((`IRDA_CNT_W+2)'(per) * 3) >> 4);
    slack = (`IRDA_CNT_W+2)'(per / `IRDA_SLACK_DIV);
    if (slack < (`IRDA_CNT_W+2)'(EXTRA_PULSE)) begin
      slack = (`IRDA_CNT_W+2)'(EXTRA_PULSE);
    end
    upper = three16 + slack;
    // Code zero is the default fraction, others a power-of-two count
    if (sel == `IRDA_PWS_DEFAULT) begin
      w = three16;
    end else begin
      w = (`IRDA_CNT_W+2)'(1) << sel;
    end
    // Upper bound first, so the minimum always wins
    if (w > upper) begin
      w = upper;
    end
    if (w < (`IRDA_CNT_W+2)'(MIN_PULSE)) begin
      w = (`IRDA_CNT_W+2)'(MIN_PULSE);
    end
    return w[`IRDA_CNT_W-1:0];
  endfunction

  // Rate comes from software; too short a period is floored
  assign period = (bit_period_cycles < MIN_PERIOD) ? MIN_PERIOD : bit_period_cycles;
  assign width = pulse_width(pulse_width_select, period);

  ////////////////////////////////////////////////////////////////////
  // Transmit bit buffer
  ////////////////////////////////////////////////////////////////////

  // Sampler fills it, pulse generator drains it once a cell
  assign sample_now = (s_r.enc == ENC_RUN) && (s_r.cell_cnt == (period >> 1));
  assign gen_free = !s_r.gen_busy || (s_r.gen_cnt == period - 1'b1);

  irda_bit_fifo #(
    .WIDTH(1),
    .DEPTH(`IRDA_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(sample_now),
    .in_ready(fifo_in_ready),
    .in_data(serial_tx_line_ch0),
    .out_valid(fifo_out_valid),
    .out_ready(gen_free),
    .out_data(fifo_bit)
  );

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  ////////////////////////////////////////////////////////////////////

  // Rising edge only once the second and third stages agree
  assign rx_rise = (s_r.rx_sync[1] == s_r.rx_sync[2]) && s_r.rx_sync[2] && !s_r.rx_level;

  always_comb begin
    s_nxt = s_r;
    // Pin synchroniser: pin into stage 0, stage 0 into stage 1, stage 1 into stage 2
    s_nxt.rx_sync = {s_r.rx_sync[1:0], infrared_rx_pin};
    if (s_r.rx_sync[1] == s_r.rx_sync[2]) begin
      s_nxt.rx_level = s_r.rx_sync[2];
    end

    // Sampler: starts on the start bit, walks one frame
    case (s_r.enc)
      ENC_IDLE: begin
        s_nxt.cell_cnt = '0;
        s_nxt.frame_cnt = '0;
        if (infrared_enable && !serial_tx_line_ch0) begin
          s_nxt.enc = ENC_RUN;
        end
      end
      default: begin
        // Full buffer holds the cell counter, stalling the sampler
        if (sample_now && !fifo_in_ready) begin
          s_nxt.cell_cnt = s_r.cell_cnt;
        end else if (s_r.cell_cnt >= period - 1'b1) begin
          s_nxt.cell_cnt = '0;
        end else begin
          s_nxt.cell_cnt = s_r.cell_cnt + 1'b1;
        end
        if (sample_now && fifo_in_ready) begin
          s_nxt.frame_cnt = s_r.frame_cnt + 1'b1;
          if (s_r.frame_cnt == LAST_CELL) begin
            s_nxt.enc = ENC_IDLE;
          end
        end
        // Dropping enable abandons the frame
        if (!infrared_enable) begin
          s_nxt.enc = ENC_IDLE;
        end
      end
    endcase

    // Pulse generator: one bit cell per buffered bit
    if (gen_free && fifo_out_valid) begin
      s_nxt.gen_busy = 1'b1;
      s_nxt.gen_bit = fifo_bit;
      s_nxt.gen_cnt = '0;
    end else if (gen_free) begin
      s_nxt.gen_busy = 1'b0;
      s_nxt.gen_cnt = '0;
    end else begin
      s_nxt.gen_cnt = s_r.gen_cnt + 1'b1;
    end
    // High only for a zero bit and only inside the width
    s_nxt.ir_tx = infrared_enable && s_nxt.gen_busy && !s_nxt.gen_bit
      && (s_nxt.gen_cnt < width);
    // Only one-clock glitches are filtered: any pulse of two or more clocks is a zero
    if (rx_rise) begin
      s_nxt.rx_hold = period;
    end else if (s_r.rx_hold != '0) begin
      s_nxt.rx_hold = s_r.rx_hold - 1'b1;
    end
    // Disabled codec idles the receive line at mark
    s_nxt.ser_rx = !infrared_enable || (s_nxt.rx_hold == '0);
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{enc: ENC_IDLE, ser_rx: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign infrared_tx_pin = s_r.ir_tx;
  assign serial_rx_line_ch0 = s_r.ser_rx;

  ////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////

  logic [`IRDA_CNT_W-1:0] hi_len_r; // Length of current high run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_len_r <= '0;
    end else if (infrared_tx_pin) begin
      hi_len_r <= hi_len_r + 1'b1;
    end else begin
      hi_len_r <= '0;
    end
  end

  property p_off_no_pulse;
    @(posedge clk) disable iff (!resetn)
      !infrared_enable |=> !infrared_tx_pin && serial_rx_line_ch0;
  endproperty
  a_off_no_pulse: assert property (p_off_no_pulse) else $error("pins active while disabled");

  property p_zero_pulses;
    @(posedge clk) disable iff (!resetn)
      gen_free && fifo_out_valid && !fifo_bit && infrared_enable |=> infrared_tx_pin;
  endproperty
  a_zero_pulses: assert property (p_zero_pulses) else $error("zero bit gave no pulse");

  property p_one_quiet;
    @(posedge clk) disable iff (!resetn)
      s_r.gen_busy && s_r.gen_bit |-> !infrared_tx_pin;
  endproperty
  a_one_quiet: assert property (p_one_quiet) else $error("pulse during a one bit");

  property p_width_sel;
    @(posedge clk) disable iff (!resetn)
      $fell(infrared_tx_pin) && $stable(pulse_width_select) && $stable(period)
        && $past(infrared_enable) && !$past(s_r.gen_cnt == period - 1'b1)
        |-> hi_len_r == $past(width);
  endproperty
  a_width_sel: assert property (p_width_sel) else $error("pulse width differs from select");

  property p_width_min;
    @(posedge clk) disable iff (!resetn)
      $fell(infrared_tx_pin) && $past(infrared_enable) && $past(s_r.gen_busy)
        && s_r.gen_cnt == $past(width) |-> hi_len_r >= MIN_PULSE;
  endproperty
  a_width_min: assert property (p_width_min) else $error("pulse shorter than minimum");

  property p_sel_reach;
    @(posedge clk) disable iff (!resetn)
      pulse_width_select != `IRDA_PWS_DEFAULT |-> width >= MIN_PULSE && width != '0;
  endproperty
  a_sel_reach: assert property (p_sel_reach) else $error("select gives too short a width");

  property p_rx_zero;
    @(posedge clk) disable iff (!resetn)
      rx_rise && infrared_enable |=> !serial_rx_line_ch0;
  endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("received pulse not seen as zero");

  property p_rx_short;
    @(posedge clk) disable iff (!resetn)
      (rx_rise && infrared_enable) ##1 infrared_enable |=> !serial_rx_line_ch0;
  endproperty
  a_rx_short: assert property (p_rx_short) else $error("short pulse zero not held");

  property p_count_start;
    @(posedge clk) disable iff (!resetn)
      $rose(infrared_tx_pin) |-> s_r.gen_cnt == '0;
  endproperty
  a_count_start: assert property (p_count_start) else $error("pulse not at cell start");
endmodule
`default_nettype wire

// [irda_xcvr_model.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Behavioural infrared transceiver on the far side of the codec
module irda_xcvr_model (
  input wire logic clk,
  input wire logic infrared_tx_pin,
  output logic infrared_rx_pin
);
  int widths[$]; // Measured transmit pulse widths, in clocks
  int run_len; // Clocks seen high so far

  // Receiver output is actively driven low when no light arrives
  initial begin
    infrared_rx_pin = 1'b0;
    run_len = 0;
  end

  // Width meter on the falling edge, where the pin has settled
  always @(negedge clk) begin
    if (infrared_tx_pin === 1'b1) begin
      run_len++;
    end else if (run_len != 0) begin
      widths.push_back(run_len);
      run_len = 0;
    end
  end

  // Light pulse toward the codec, launched off a falling edge
  task automatic emit(input int w);
    infrared_rx_pin = 1'b1;
    repeat (w) @(negedge clk);
    infrared_rx_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "irda_defs.svh"
////////////////////////////////////////////////////////////////
// Self-checking bench for the infrared pulse codec
module tb_top;
  import irda_pkg::*;
  logic clk, resetn, infrared_enable, serial_tx_line_ch0, serial_rx_line_ch0;
  logic infrared_rx_pin, infrared_tx_pin; // Optical side
  logic [2:0] pulse_width_select; // Transmit width code
  logic [15:0] bit_period_cycles; // Clocks per bit cell
  int n_errors = 0; // Mismatches seen
  int n_compared = 0; // Comparisons made

  irda_pulse_codec irda_pulse_codec_i (
    .clk(clk), .resetn(resetn), .infrared_enable(infrared_enable),
    .pulse_width_select(pulse_width_select), .bit_period_cycles(bit_period_cycles),
    .serial_tx_line_ch0(serial_tx_line_ch0), .serial_rx_line_ch0(serial_rx_line_ch0),
    .infrared_rx_pin(infrared_rx_pin), .infrared_tx_pin(infrared_tx_pin)
  );
  irda_xcvr_model irda_xcvr_model_i (
    .clk(clk), .infrared_tx_pin(infrared_tx_pin), .infrared_rx_pin(infrared_rx_pin)
  );

  ////////////////////////////////////////////////////////////////
  // Report, verdict and compares
  task automatic tally_and_finish;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_num(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Expected pulse width: select code, then upper clamp, then the floor
  function automatic logic [15:0] exp_width(input logic [2:0] sel, input int per);
    int p, w, up;
    p = (per < 16) ? 16 : per;
    w = (sel == 3'h0) ? (3 * p) / 16 : (1 << sel);
    up = (3 * p) / 16 + (((p / 40) > `IRDA_EXTRA_PULSE_CYC) ? p / 40 : `IRDA_EXTRA_PULSE_CYC);
    if (w > up) w = up;
    if (w < `IRDA_MIN_PULSE_CYC) w = `IRDA_MIN_PULSE_CYC;
    return w[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // One UART frame out, then count and size the light pulses
  task automatic tx_frame(input logic [7:0] d, input int per, input logic [2:0] sel,
                          input logic en);
    logic [9:0] cells;
    int zeros;
    cells = {1'b1, d, 1'b0};
    zeros = 0;
    infrared_enable = en;
    bit_period_cycles = per[15:0];
    pulse_width_select = sel;
    irda_xcvr_model_i.widths.delete();
    for (int i = 0; i < 10; i++) begin
      serial_tx_line_ch0 = cells[i];
      if (!cells[i]) zeros++;
      repeat (per) @(negedge clk);
    end
    // Output lags the line by about half a cell; let it drain
    repeat (2 * per) @(negedge clk);
    if (!en) zeros = 0;
    chk_num(irda_xcvr_model_i.widths.size(), zeros);
    foreach (irda_xcvr_model_i.widths[k]) begin
      chk_num(irda_xcvr_model_i.widths[k], exp_width(sel, per));
    end
  endtask

  // One light frame in, sampling the decoded line at mid cell
  task automatic rx_frame(input logic [7:0] d, input int per, input logic en);
    logic [9:0] cells;
    int w;
    cells = {1'b1, d, 1'b0};
    infrared_enable = en;
    bit_period_cycles = per[15:0];
    for (int i = 0; i < 10; i++) begin
      // Far too short for a legal pulse, yet it must still decode
      w = (i == 1) ? 2 : 2 + $urandom_range(per / 4);
      if (!cells[i]) begin
        irda_xcvr_model_i.emit(w);
      end else begin
        repeat (w) @(negedge clk);
      end
      repeat (per / 2 - w) @(negedge clk);
      chk_bit(serial_rx_line_ch0, en ? cells[i] : 1'b1);
      repeat (per - per / 2) @(negedge clk);
    end
    repeat (per) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    resetn = 1'b0;
    infrared_enable = 1'b0;
    pulse_width_select = 3'h0;
    // Link comes up at the boot rate; frames below reprogram it
    bit_period_cycles = 16'(`IRDA_CLK_MHZ * 1000000 / `IRDA_BOOT_BPS);
    serial_tx_line_ch0 = 1'b1;
    void'($urandom(26));
    repeat (12) @(negedge clk);
    chk_bit(infrared_tx_pin, 1'b0);
    chk_bit(serial_rx_line_ch0, 1'b1);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    // Back-to-back zero cells at the default width
    tx_frame(8'h00, 1280, 3'h0, 1'b1);
    tx_frame(8'hFF, 400, 3'h7, 1'b1);
    tx_frame(8'h5A, 800, 3'h5, 1'b1);
    // Rate of 1085 clocks per cell, legal because it lies above the 16-clock minimum period
    tx_frame(8'hA5, 1085, 3'h6, 1'b1);
    tx_frame(8'h00, 400, 3'h0, 1'b0);
    for (int n = 0; n < 3; n++) begin
      tx_frame(8'($urandom), 400, 3'($urandom_range(7)), 1'b1);
    end
    rx_frame(8'h00, 400, 1'b1);
    rx_frame(8'($urandom), 400, 1'b1);
    rx_frame(8'h3C, 400, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
